// [hdl/eeprom_bus_port.v]
// two-wire bus slave front end of a serial nonvolatile memory
`timescale 1ns/1ns
`include "eeprom_port_defs.vh"
module eeprom_bus_port #(
  // device type code; value arbitrary
  parameter [3:0] DEVICE_TYPE_CODE = 4'h5,
  // program cycle length in clocks, shortened in simulation
  parameter integer PROGRAM_CYCLES = `PROGRAM_CYCLE_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // bus pins; data line is open drain, clock is input only
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  // device select strap pins, pulled down when unconnected
  input wire [2:0] device_select_straps,
  // received write bytes toward the memory
  output wire [7:0] rx_data,
  output wire rx_first,
  output wire rx_valid,
  input wire rx_ready,
  // read bytes from the memory
  input wire [7:0] tx_data,
  input wire tx_valid,
  output reg tx_ready,
  // status
  output reg selected,
  output reg read_mode,
  output reg program_busy,
  output reg program_done
);

// one-hot bus states
localparam [4:0] ST_IDLE = 5'h01;
localparam [4:0] ST_ADDR = 5'h02;
localparam [4:0] ST_WRITE = 5'h04;
localparam [4:0] ST_READ = 5'h08;
localparam [4:0] ST_WAIT = 5'h10;

// last value of the program timer; the busy window is PROGRAM_CYCLES clocks long
localparam [31:0] PROG_LAST = PROGRAM_CYCLES - 1;

// synchronised bus lines, their previous values and the straps
wire scl;
wire scl_prev;
wire sda;
wire sda_prev;
wire [2:0] straps;
// decoded bus events and the address compare
wire scl_rise;
wire scl_fall;
wire start_seen;
wire stop_seen;
wire addr_match;
// room left in the receive buffer
wire buf_in_ready;
// bit-level state of the current transfer
reg [4:0] state;
reg [3:0] bit_cnt;
reg [7:0] shift_in;
reg [7:0] shift_out;
reg first_byte;
// program cycle bookkeeping
reg wrote_data;
reg [31:0] prog_cnt;
// word handed to the receive buffer
reg buf_push;
reg [8:0] buf_word;

// next received byte: older bits move up, the new bit enters at the bottom
function [7:0] shift_in_bit;
  input [7:0] held;
  input bit_in;
  begin
    shift_in_bit = {held[6:0], bit_in};
  end
endfunction

// byte to send next: memory data when offered, all ones otherwise
function [7:0] next_read_byte;
  input valid;
  input [7:0] data;
  begin
    next_read_byte = valid ? data : `IDLE_READ_BYTE;
  end
endfunction

// pull on the data line for one bit of an outgoing byte; a one leaves it released
function pull_for_bit;
  input [7:0] byte_out;
  input [2:0] index;
  begin
    pull_for_bit = !byte_out[index];
  end
endfunction

// bus lines reach logic only after two flops
pin_sync #(
  .WIDTH(2),
  .RESET_VALUE(2'h3)
) u_bus_sync (
  .clk(clk),
  .rstn(rstn),
  .pin({scl_in, sda_in}),
  .level({scl, sda}),
  .level_prev({scl_prev, sda_prev})
);

// straps idle at zero, matching a floating pin
pin_sync #(
  .WIDTH(3),
  .RESET_VALUE(3'h0)
) u_strap_sync (
  .clk(clk),
  .rstn(rstn),
  .pin(device_select_straps), // R5
  .level(straps),
  .level_prev()
);

// write bytes wait here so a slow memory side loses none
two_entry_buffer #(
  .WIDTH(9)
) u_rx_buf (
  .clk(clk),
  .rstn(rstn),
  .in_data(buf_word),
  .in_valid(buf_push),
  .in_ready(buf_in_ready),
  .out_data({rx_first, rx_data}),
  .out_valid(rx_valid),
  .out_ready(rx_ready)
);

// edges of the bus; data moving with clock high marks a condition
assign scl_rise = scl && !scl_prev;
assign scl_fall = !scl && scl_prev;
assign start_seen = scl && scl_prev && sda_prev && !sda; // R7 R8
assign stop_seen = scl && scl_prev && !sda_prev && sda; // R7 R9

// address compare: type code then straps, msb first
assign addr_match =
  (shift_in[`ADDR_TYPE_MSB:`ADDR_TYPE_LSB] == DEVICE_TYPE_CODE) && // R10
  (shift_in[`ADDR_SEL_MSB:`ADDR_SEL_LSB] == straps); // R11

// program cycle timer, started by a STOP that closes a write
// a read, or a write with no data byte acknowledged, leaves the timer idle
always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    prog_cnt <= 32'h0000_0000;
    program_busy <= 1'b0;
    program_done <= 1'b0;
  end else begin
    program_done <= 1'b0;
    if (program_busy) begin
      if (prog_cnt == PROG_LAST) begin
        program_busy <= 1'b0; // R1
        program_done <= 1'b1;
      end else begin
        prog_cnt <= prog_cnt + 32'h0000_0001;
      end
    end else if (stop_seen && wrote_data) begin
      program_busy <= 1'b1; // R1
      prog_cnt <= 32'h0000_0000;
    end
  end
end

// bus state machine; bits move on sampled clock edges, START and STOP on data edges with clock high
// decisions use synchronised levels, so each bus event lags its pin by three clocks;
// the master's low phase must cover that lag before it samples our drive
always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    state <= ST_IDLE;
    bit_cnt <= 4'h0;
    shift_in <= 8'h00;
    shift_out <= 8'h00;
    sda_out <= 1'b0;
    sda_oe <= 1'b0;
    first_byte <= 1'b0;
    wrote_data <= 1'b0;
    selected <= 1'b0;
    read_mode <= 1'b0;
    tx_ready <= 1'b0;
    buf_push <= 1'b0;
    buf_word <= 9'h000;
  end else begin
    tx_ready <= 1'b0;
    buf_push <= 1'b0;
    sda_out <= 1'b0; // R4
    if (stop_seen) begin
      // operation closed; data line let go
      state <= ST_IDLE; // R9
      sda_oe <= 1'b0;
      selected <= 1'b0;
      wrote_data <= 1'b0;
    end else if (start_seen) begin
      // busy programming: stay deaf to the address
      if (program_busy) begin
        state <= ST_IDLE; // R2 R19
        sda_oe <= 1'b0;
      end else begin
        state <= ST_ADDR; // R20
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end
      selected <= 1'b0;
      // a new address opens a new operation; an earlier write no longer counts
      wrote_data <= 1'b0; // R1
    end else begin
      case (state)
        ST_IDLE: begin
          // nothing on the bus concerns us until a START
          sda_oe <= 1'b0; // R8
        end
        ST_ADDR: begin
          if (scl_rise) begin
            if (bit_cnt < `BITS_PER_BYTE) begin
              shift_in <= shift_in_bit(shift_in, sda);
            end
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == `BITS_PER_BYTE) begin
            // ack slot: pull low only on a full match
            sda_oe <= addr_match; // R13 R14
            if (!addr_match) begin
              state <= ST_IDLE;
            end
          end else if (scl_fall && bit_cnt == `ACK_SLOT_DONE) begin
            // ninth clock over: the transfer direction takes effect
            selected <= 1'b1;
            read_mode <= (shift_in[`ADDR_DIR_BIT] == `DIR_READ); // R12
            bit_cnt <= 4'h0;
            first_byte <= 1'b1;
            if (shift_in[`ADDR_DIR_BIT] == `DIR_READ) begin
              // first read bit goes out as the ack clock falls
              state <= ST_READ; // R14
              shift_out <= next_read_byte(tx_valid, tx_data);
              tx_ready <= 1'b1;
              sda_oe <= pull_for_bit(next_read_byte(tx_valid, tx_data), 3'h7); // R16
            end else begin
              state <= ST_WRITE; // R14
              sda_oe <= 1'b0;
            end
          end
        end
        ST_WRITE: begin
          // data byte: same bit timing as the address, handed over at the ack slot
          if (scl_rise) begin
            if (bit_cnt < `BITS_PER_BYTE) begin
              shift_in <= shift_in_bit(shift_in, sda);
            end
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == `BITS_PER_BYTE) begin
            // a full buffer withholds the ack instead of dropping data
            sda_oe <= buf_in_ready; // R15 R13
            buf_push <= buf_in_ready;
            buf_word <= {first_byte, shift_in};
            if (buf_in_ready) begin
              wrote_data <= 1'b1;
              first_byte <= 1'b0;
            end
          end else if (scl_fall && bit_cnt == `ACK_SLOT_DONE) begin
            sda_oe <= 1'b0;
            bit_cnt <= 4'h0;
          end
        end
        ST_READ: begin
          // outgoing byte: each bit is set up after the fall that ends the one before
          if (scl_rise) begin
            if (bit_cnt == `BITS_PER_BYTE && sda) begin
              // master declined more data
              state <= ST_WAIT; // R17
            end
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt < `BITS_PER_BYTE) begin
              sda_oe <= pull_for_bit(shift_out, 3'h7 - bit_cnt[2:0]); // R16
            end else if (bit_cnt == `BITS_PER_BYTE) begin
              sda_oe <= 1'b0; // R16
            end else begin
              // acknowledged: next byte, msb driven now
              bit_cnt <= 4'h0;
              shift_out <= next_read_byte(tx_valid, tx_data);
              tx_ready <= 1'b1;
              sda_oe <= pull_for_bit(next_read_byte(tx_valid, tx_data), 3'h7); // R16
            end
          end
        end
        ST_WAIT: begin
          // master declined; hold off until a STOP or a fresh START
          sda_oe <= 1'b0; // R17
        end
        default: begin
          // illegal code: fall back to idle with the line released
          state <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end
end

endmodule // eeprom_bus_port

// [hdl/eeprom_port_defs.vh]
// constants and behaviour list for the two-wire memory bus slave port
// Function
// [R1] after a STOP ending a write, finish programming within 10 ms
// [R2] while programming, keep data line released and ignore own address
// [R3] master makes the clock and all STARTs and STOPs; we never drive clock
// [R4] data line is open drain: pull low or release only
// [R5] unconnected device select straps count as logic zero
// [R6] master starts a transfer only when the bus is idle
// [R7] data changes only with clock low; change with clock high is START/STOP
// [R8] data falling with clock high is START; ignore the bus until one
// [R9] data rising with clock high is STOP; master ends every operation so
// [R10] upper nibble of the address byte must equal the device type code
// [R11] next three address bits must equal the straps, msb first
// [R12] address lsb is direction: 1 read, 0 write
// [R13] receiver holds data low on the ninth clock to acknowledge
// [R14] acknowledge the address byte only on a match, then read or write
// [R15] when selected for write, acknowledge every received byte; the code withholds the ack while the receive buffer is full
// [R16] read: shift out 8 bits, release, sample ack, continue on ack
// [R17] on master no-ack after a read byte, stop sending, wait for STOP
// [R18] master waits up to 1 ms after power is stable before operating
// [R19] ack polling: address with write direction gets no ack while busy
// [R20] any START, even repeated, returns to address reception
`ifndef EEPROM_PORT_DEFS_VH
`define EEPROM_PORT_DEFS_VH

// system clock in kHz
`define CLK_FREQ_KHZ 50000
// program cycle time, longest, in ms
`define PROGRAM_CYCLE_TIME_MS 10
// power-up delays owed by the master, in ms
`define POWERUP_READ_DELAY_MS 1
`define POWERUP_WRITE_DELAY_MS 1
// program cycle in clock cycles, rounded down
`define PROGRAM_CYCLE_CYCLES (`PROGRAM_CYCLE_TIME_MS * `CLK_FREQ_KHZ)

// address byte field positions
`define ADDR_TYPE_MSB 7
`define ADDR_TYPE_LSB 4
`define ADDR_SEL_MSB 3
`define ADDR_SEL_LSB 1
`define ADDR_DIR_BIT 0
// direction flag values
`define DIR_READ 1'h1
// bit count at which the ninth clock (ack slot) is reached
`define BITS_PER_BYTE 4'h8
`define ACK_SLOT_DONE 4'h9
// byte sent when no read data is offered
`define IDLE_READ_BYTE 8'hff

`endif

// [hdl/pin_sync.v]
// two flip-flop synchroniser with a delayed copy for edge finding
`timescale 1ns/1ns
module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // pin side
  input wire [WIDTH-1:0] pin,
  // synchronised level and its previous value
  output reg [WIDTH-1:0] level,
  output reg [WIDTH-1:0] level_prev
);

reg [WIDTH-1:0] meta;

// first stage is read only by the second stage
always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    meta <= RESET_VALUE;
    level <= RESET_VALUE;
    level_prev <= RESET_VALUE;
  end else begin
    meta <= pin;
    level <= meta;
    level_prev <= level;
  end
end

endmodule // pin_sync

// [hdl/two_entry_buffer.v]
// two-entry buffer with valid/ready on both sides, output held in flops
`timescale 1ns/1ns
module two_entry_buffer #(
  parameter WIDTH = 9
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // filling side
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  // draining side
  output reg [WIDTH-1:0] out_data,
  output reg out_valid,
  input wire out_ready
);

reg [WIDTH-1:0] spare;
reg spare_valid;
wire push;
wire pop;

// full only when both entries hold words
assign in_ready = !spare_valid;
assign push = in_valid && in_ready;
assign pop = out_valid && out_ready;

// the spare entry catches a word while the drain stalls
always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    out_data <= {WIDTH{1'b0}};
    out_valid <= 1'b0;
    spare <= {WIDTH{1'b0}};
    spare_valid <= 1'b0;
  end else if (pop) begin
    if (spare_valid) begin
      out_data <= spare;
      spare_valid <= 1'b0;
    end else if (push) begin
      out_data <= in_data;
    end else begin
      out_valid <= 1'b0;
    end
  end else if (push) begin
    if (!out_valid) begin
      out_data <= in_data;
      out_valid <= 1'b1;
    end else begin
      spare <= in_data;
      spare_valid <= 1'b1;
    end
  end
end

endmodule // two_entry_buffer

// [tb/bus_master_model.sv]
// two-wire bus master model: makes the clock and drives data open drain
`timescale 1ns/1ns
module bus_master_model (
  // step timing
  input wire clk,
  // bus lines
  input wire sda,
  output reg scl,
  output reg sda_oe
);
  // clock idles high between frames; only the master makes it
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // wait n system clocks, then act just after the edge
  task step(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // data set one clock into the low phase, sampled late in the high phase
  task clk_bit(input logic b, output logic seen);
    step(1);
    sda_oe = !b;
    step(3);
    scl = 1'b1;
    step(3);
    seen = sda;
    step(1);
    scl = 1'b0;
  endtask
  // clock pulled low with no start, so later data moves only while it is low
  task clock_low;
    step(4);
    scl = 1'b0;
  endtask
  // start from idle or repeated; data released before the clock is raised
  task start;
    step(1);
    sda_oe = 1'b0;
    step(3);
    scl = 1'b1;
    step(4);
    sda_oe = 1'b1;
    step(4);
    scl = 1'b0;
  endtask
  // every operation closes with a stop
  task stop;
    step(1);
    sda_oe = 1'b1;
    step(3);
    scl = 1'b1;
    step(4);
    sda_oe = 1'b0;
    step(4);
  endtask
  // byte out msb first, then release for the slave's ack
  task wbyte(input logic [7:0] d, output logic ack);
    integer i;
    logic s;
    for (i = 7; i >= 0; i = i - 1) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask
  // byte in, then our own ack or no-ack
  task rbyte(output logic [7:0] d, input logic ack);
    integer i;
    logic s;
    for (i = 7; i >= 0; i = i - 1) clk_bit(1'b1, d[i]);
    clk_bit(!ack, s);
  endtask
endmodule // bus_master_model

// [tb/eeprom_bus_port_monitor.sv]
// assertion checker for the two-wire memory bus slave port
`timescale 1ns/1ns
module eeprom_bus_port_monitor #(
  parameter integer PROGRAM_CYCLES = 500000
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // bus drive
  input wire sda_out,
  input wire sda_oe,
  // streams
  input wire [7:0] rx_data,
  input wire rx_first,
  input wire rx_valid,
  input wire rx_ready,
  input wire tx_ready,
  // status
  input wire selected,
  input wire read_mode,
  input wire program_busy,
  input wire program_done
);
  integer busy_cnt;
  // length of the current busy stretch, so an endless cycle is caught
  always @(posedge clk or negedge rstn) begin
    if (!rstn) busy_cnt <= 0;
    else if (program_busy) busy_cnt <= busy_cnt + 1;
    else busy_cnt <= 0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  drive_low_only_a: assert property (sda_out == 1'b0) else $error("data driven high");
  quiet_busy_a: assert property (program_busy |-> !sda_oe) else $error("drive while busy");
  deaf_busy_a: assert property (program_busy |-> !selected)
    else $error("selected while busy");
  busy_bound_a: assert property (busy_cnt <= PROGRAM_CYCLES) else $error("cycle too long");
  done_pulse_a: assert property (program_done |=> !program_done)
    else $error("done too long");
  write_prog_a: assert property ($rose(program_busy) |-> !read_mode)
    else $error("read programs");
  read_feed_a: assert property (tx_ready |-> ##[0:2] read_mode)
    else $error("feed not read");
  feed_pulse_a: assert property (tx_ready |=> !tx_ready) else $error("feed too long");
  rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data)
    && $stable(rx_first)) else $error("word lost");
  cover property (program_done);
  cover property (tx_ready);
  cover property (rx_valid && rx_first);
endmodule // eeprom_bus_port_monitor
bind eeprom_bus_port eeprom_bus_port_monitor #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) mon (
  .clk(clk), .rstn(rstn), .sda_out(sda_out), .sda_oe(sda_oe), .rx_data(rx_data),
  .rx_first(rx_first), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_ready(tx_ready),
  .selected(selected), .read_mode(read_mode), .program_busy(program_busy),
  .program_done(program_done));

// [tb/test_eeprom_bus_port.sv]
// self-checking bench for the two-wire memory bus slave port
`timescale 1ns/1ns
module test_eeprom_bus_port;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg rx_ready = 1'b1;
  reg [7:0] tx_data = 8'ha5;
  reg tx_valid = 1'b1;
  reg [2:0] device_select_straps = 3'h3;
  wire scl, m_oe, sda_out, sda_oe, rx_first, rx_valid, tx_ready;
  wire selected, read_mode, program_busy, program_done;
  wire [7:0] rx_data;
  // pull-up on the data line; either party may pull it low
  wire sda = !((sda_oe && !sda_out) || m_oe);
  integer err_count = 0;
  integer checks = 0;
  logic ack;
  logic [7:0] b;
  always #10 clk = !clk;
  // memory side offers the next read byte once one is taken
  always @(posedge clk) if (tx_ready) tx_data <= 8'h3c;
  eeprom_bus_port #(.PROGRAM_CYCLES(200)) dut (.clk(clk), .rstn(rstn), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .device_select_straps(device_select_straps), .rx_data(rx_data), .rx_first(rx_first),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .selected(selected), .read_mode(read_mode),
    .program_busy(program_busy), .program_done(program_done));
  bus_master_model m (.clk(clk), .sda(sda), .scl(scl), .sda_oe(m_oe));
  task chk1(input string what, input logic e, input logic g);
    checks = checks + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask
  task chk8(input string what, input logic [7:0] e, input logic [7:0] g);
    checks = checks + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // bounded wait on the program cycle flag; running out ends the run
  task wait_busy(input logic v);
    integer n;
    n = 0;
    while (program_busy !== v && n < 1000) begin
      @(posedge clk);
      #1;
      n = n + 1;
    end
    chk1("program_busy", v, program_busy);
    if (n == 1000) conclude;
  endtask
  // wrong address: no ack, then the device idles until the next start
  task try_addr(input logic [7:0] a);
    m.start;
    m.wbyte(a, ack);
    chk1("nack", 1'b0, ack);
    m.stop;
  endtask
  // bits clocked with no start before them must find the device deaf
  task no_start;
    m.clock_low;
    m.wbyte(8'h56, ack);
    chk1("no start", 1'b0, ack);
    m.step(3);
    chk1("selected", 1'b0, selected);
    m.stop;
  endtask
  // write held by a stalled consumer, then polling and a read
  task write_poll_read;
    rx_ready = 1'b0;
    m.start;
    m.wbyte(8'h56, ack);
    chk1("addr ack", 1'b1, ack);
    m.wbyte(8'h12, ack);
    chk1("byte ack", 1'b1, ack);
    m.wbyte(8'h34, ack);
    chk1("byte ack", 1'b1, ack);
    m.wbyte(8'h77, ack);
    chk1("full nack", 1'b0, ack);
    chk8("rx_data", 8'h12, rx_data);
    chk1("rx_first", 1'b1, rx_first);
    rx_ready = 1'b1;
    m.step(1);
    chk8("rx_data", 8'h34, rx_data);
    chk1("rx_first", 1'b0, rx_first);
    m.step(1);
    chk1("rx_valid", 1'b0, rx_valid);
    m.stop;
    wait_busy(1'b1);
    m.start;
    m.wbyte(8'h56, ack);
    chk1("poll busy", 1'b0, ack);
    m.stop;
    wait_busy(1'b0);
    chk1("program_done", 1'b1, program_done);
    m.start;
    m.wbyte(8'h56, ack);
    chk1("poll done", 1'b1, ack);
    m.wbyte(8'h9a, ack);
    chk1("dummy ack", 1'b1, ack);
    m.start;
    m.wbyte(8'h57, ack);
    chk1("read ack", 1'b1, ack);
    m.step(3);
    chk1("read_mode", 1'b1, read_mode);
    chk1("selected", 1'b1, selected);
    m.rbyte(b, 1'b1);
    chk8("read byte", 8'ha5, b);
    m.rbyte(b, 1'b0);
    chk8("read byte", 8'h3c, b);
    m.rbyte(b, 1'b1);
    chk8("after nack", 8'hff, b);
    m.stop;
    chk1("read programs", 1'b0, program_busy);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rstn = 1'b1;
    m.step(4);
    no_start;
    try_addr(8'h76);
    try_addr(8'h54);
    try_addr(8'h5e);
    write_poll_read;
    conclude;
  end
endmodule // test_eeprom_bus_port
